/* File: sso_pkg.sv */
package sso_pkg;
	// Register indices; the byte address on the bus is four times the index.
	localparam logic [7:0] SSO_IDX_PERF_LOAD = 8'h05;
	localparam logic [7:0] SSO_IDX_RX_CTRL   = 8'h10;
	localparam logic [7:0] SSO_IDX_RX_STAT   = 8'h11;
	localparam logic [7:0] SSO_IDX_CNT_LOW   = 8'h12;
	localparam logic [7:0] SSO_IDX_CNT_HIGH  = 8'h13;
	localparam logic [7:0] SSO_IDX_TX_CTRL   = 8'h14;
	localparam logic [7:0] SSO_IDX_TX_DIAG   = 8'h15;
	// Receive control field positions.
	localparam int SSO_B_OOF_IE    = 0;
	localparam int SSO_B_LOF_IE    = 1;
	localparam int SSO_B_LOS_IE    = 2;
	localparam int SSO_B_PAR_IE    = 3;
	localparam int SSO_B_ALT_FRM   = 4;
	localparam int SSO_B_FORCE_OOF = 5;
	localparam int SSO_B_DESCR_DIS = 6;
	localparam int SSO_B_BLOCK_ACC = 7;
	// Receive status field positions; the sticky bits sit at state bit plus three.
	localparam int SSO_B_OOF_ST    = 0;
	localparam int SSO_B_PAR_IS    = 6;
	localparam int SSO_IS_OFS      = 3;
	// Transmit control and diagnostic field positions.
	localparam int SSO_B_AIS       = 0;
	localparam int SSO_B_SCR_DIS   = 6;
	localparam int SSO_B_A1_DIAG   = 0;
	localparam int SSO_B_B1_DIAG   = 1;
	localparam int SSO_B_ZERO_DIAG = 2;
	// Writable masks and reset value.
	localparam logic [7:0] SSO_RX_CTRL_MASK = 8'hDF;
	localparam logic [7:0] SSO_TX_CTRL_MASK = 8'h7F;
	localparam logic [7:0] SSO_TX_DIAG_MASK = 8'h07;
	localparam logic [7:0] SSO_REG_RESET    = 8'h00;
	// Frame layout of an STS-3c frame, one byte per enable.
	localparam int SSO_COLS       = 270;
	localparam int SSO_ROWS       = 9;
	localparam int SSO_SOH_COLS   = 9;
	localparam int SSO_SOH_ROWS   = 3;
	localparam int SSO_A1_BYTES   = 3;
	localparam int SSO_A2_LAST    = 5;
	localparam int SSO_B1_ROW     = 1;
	localparam logic [7:0] SSO_A1     = 8'hF6;
	localparam logic [7:0] SSO_A1_BAD = 8'h76;
	localparam logic [7:0] SSO_A2     = 8'h28;
	localparam logic [7:0] SSO_ONES   = 8'hFF;
	localparam logic [7:0] SSO_ZERO   = 8'h00;
	localparam logic [6:0] SSO_SCR_SEED = 7'h7F;
	// Framer states, Gray coded along hunt, presync, sync.
	typedef enum logic [1:0] {
		SSO_HUNT    = 2'b00,
		SSO_PRESYNC = 2'b01,
		SSO_SYNC    = 2'b11
	} sso_frm_t;
endpackage

/* File: sso_section_proc.sv */
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sso_section_proc
	import sso_pkg::*;
#(
	parameter int OOF_BAD_FRAMES = 4,
	parameter int LOF_FRAMES     = 24,
	parameter int LOS_ZERO_BYTES = 389
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	output logic             sec_irq,
	input  wire logic        rx_byte_en,
	input  wire logic [7:0]  rx_data,
	output logic             rx_out_valid,
	output logic [7:0]       rx_out_data,
	output logic             rx_out_frame_start,
	input  wire logic        tx_byte_en,
	input  wire logic [7:0]  tx_in_data,
	output logic             tx_out_valid,
	output logic [7:0]       tx_out_data
);
	// One scrambler byte: key in the low eight bits, next state above it.
	function automatic logic [14:0] scr_step(input logic [6:0] st);
		logic [6:0] s;
		logic [7:0] k;
		s = st;
		k = SSO_ZERO;
		for (int i = 7; i >= 0; i--) begin
			k[i] = s[6];
			s = {s[5:0], s[6] ^ s[5]};
		end
		return {s, k};
	endfunction

	function automatic logic [3:0] ones8(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'b000, v[i]};
		end
		return n;
	endfunction

	logic [7:0]  rx_ctrl;
	logic [7:0]  tx_ctrl;
	logic [7:0]  tx_diag;
	logic [3:0]  irq_sticky;
	logic        force_pend;
	logic [15:0] err_count;
	logic [15:0] err_snap;
	logic        dp_write;
	logic [7:0]  dp_idx;
	sso_frm_t    frm_state;
	logic [8:0]  rx_col;
	logic [3:0]  rx_row;
	logic [47:0] rx_shift;
	logic [7:0]  bad_frames;
	logic [7:0]  lof_frames;
	logic        lof_state;
	logic [15:0] zero_bytes;
	logic        los_state;
	logic [6:0]  rx_lfsr;
	logic [7:0]  rx_bip;
	logic [7:0]  rx_bip_prev;
	logic        par_err;
	logic [3:0]  alarm_prev;
	logic [8:0]  tx_col;
	logic [3:0]  tx_row;
	logic        ais_on;
	logic [6:0]  tx_lfsr;
	logic [7:0]  tx_bip;
	logic [7:0]  tx_bip_prev;

	// Bus decode; address phase is taken when the bus is ready and a transfer is live.
	wire        addr_ok   = hsel && hready && htrans[1];
	wire [7:0]  addr_idx  = {2'b00, haddr[7:2]};
	wire        rd_take   = addr_ok && !hwrite;
	wire        stat_read = rd_take && (addr_idx == SSO_IDX_RX_STAT);
	wire [7:0]  wbyte     = hwdata[7:0];
	wire        wr_rx     = dp_write && (dp_idx == SSO_IDX_RX_CTRL);
	wire        wr_tx     = dp_write && (dp_idx == SSO_IDX_TX_CTRL);
	wire        wr_diag   = dp_write && (dp_idx == SSO_IDX_TX_DIAG);
	wire        poll      = dp_write && (dp_idx == SSO_IDX_CNT_LOW || dp_idx == SSO_IDX_CNT_HIGH
		|| dp_idx == SSO_IDX_PERF_LOAD);

	// Receive framing position and pattern checks.
	wire        oof_state = (frm_state != SSO_SYNC);
	wire [47:0] shift_nx  = {rx_shift[39:0], rx_data};
	wire        match_all = (shift_nx == {SSO_A1, SSO_A1, SSO_A1, SSO_A2, SSO_A2, SSO_A2});
	wire        match_alt = (shift_nx[47:40] == SSO_A1) && (shift_nx[7:4] == SSO_A2[7:4]);
	wire        frm_match = rx_ctrl[SSO_B_ALT_FRM] ? match_alt : match_all;
	wire        rx_fp     = rx_byte_en && (rx_row == 4'd0) && (rx_col == 9'(SSO_A2_LAST));
	wire        rx_col_end = (rx_col == 9'(SSO_COLS - 1));
	wire        rx_row_end = (rx_row == 4'(SSO_ROWS - 1));
	wire        rx_row0   = (rx_row == 4'd0);
	wire        rx_soh0   = rx_row0 && (rx_col < 9'(SSO_SOH_COLS));
	wire        rx_first  = rx_row0 && (rx_col == 9'd0);
	wire        rx_b1     = (rx_row == 4'(SSO_B1_ROW)) && (rx_col == 9'd0);

	// Descrambler keyed by the frame position.
	wire        rx_seed   = rx_row0 && (rx_col == 9'(SSO_SOH_COLS));
	wire [14:0] rx_step   = scr_step(rx_seed ? SSO_SCR_SEED : rx_lfsr);
	wire        rx_descr  = !rx_ctrl[SSO_B_DESCR_DIS] && !rx_soh0;
	wire [7:0]  rx_clear  = rx_data ^ (rx_descr ? rx_step[7:0] : SSO_ZERO);

	// Section parity check against the previous frame's parity.
	wire [7:0]  b1_diff   = rx_clear ^ rx_bip_prev;
	wire        b1_check  = rx_byte_en && rx_b1 && (frm_state == SSO_SYNC);
	wire [3:0]  b1_bits   = b1_check ? ones8(b1_diff) : 4'h0;
	wire [3:0]  err_inc   = rx_ctrl[SSO_B_BLOCK_ACC] ? {3'b000, |b1_bits} : b1_bits;
	wire [15:0] next_count = poll ? {12'h000, err_inc} : err_count + {12'h000, err_inc};

	// Alarm change detection and sticky status.
	wire [3:0]  alarm_now = {1'b0, los_state, lof_state, oof_state};
	wire [3:0]  irq_set   = {par_err, (alarm_now[2:0] ^ alarm_prev[2:0])};
	wire [3:0]  next_sticky = irq_set | (stat_read ? 4'h0 : irq_sticky);
	wire [3:0]  irq_en    = {rx_ctrl[SSO_B_PAR_IE], rx_ctrl[SSO_B_LOS_IE], rx_ctrl[SSO_B_LOF_IE],
		rx_ctrl[SSO_B_OOF_IE]};
	wire [7:0]  stat_byte = {1'b0, irq_sticky[3:0], los_state, lof_state, oof_state};

	// Read multiplexer; the force bit reads back as zero.
	wire [7:0]  rd_byte   =
		(addr_idx == SSO_IDX_RX_CTRL)  ? rx_ctrl :
		(addr_idx == SSO_IDX_RX_STAT)  ? stat_byte :
		(addr_idx == SSO_IDX_CNT_LOW)  ? err_snap[7:0] :
		(addr_idx == SSO_IDX_CNT_HIGH) ? err_snap[15:8] :
		(addr_idx == SSO_IDX_TX_CTRL)  ? tx_ctrl :
		(addr_idx == SSO_IDX_TX_DIAG)  ? tx_diag : SSO_ZERO;

	// Transmit byte building.
	wire        tx_col_end = (tx_col == 9'(SSO_COLS - 1));
	wire        tx_row_end = (tx_row == 4'(SSO_ROWS - 1));
	wire        tx_row0   = (tx_row == 4'd0);
	wire        tx_first  = tx_row0 && (tx_col == 9'd0);
	wire        tx_soh    = (tx_row < 4'(SSO_SOH_ROWS)) && (tx_col < 9'(SSO_SOH_COLS));
	wire        tx_soh0   = tx_row0 && (tx_col < 9'(SSO_SOH_COLS));
	wire        tx_is_a1  = tx_row0 && (tx_col < 9'(SSO_A1_BYTES));
	wire        tx_is_a2  = tx_row0 && !tx_is_a1 && (tx_col <= 9'(SSO_A2_LAST));
	wire        tx_is_b1  = (tx_row == 4'(SSO_B1_ROW)) && (tx_col == 9'd0);
	wire        ais_nx    = tx_first ? tx_ctrl[SSO_B_AIS] : ais_on;
	wire [7:0]  tx_a1     = tx_diag[SSO_B_A1_DIAG] ? SSO_A1_BAD : SSO_A1;
	wire [7:0]  tx_b1     = tx_bip_prev ^ (tx_diag[SSO_B_B1_DIAG] ? SSO_ONES : SSO_ZERO);
	wire [7:0]  tx_plain  =
		tx_is_a1 ? tx_a1 :
		tx_is_a2 ? SSO_A2 :
		tx_is_b1 ? tx_b1 :
		(ais_nx && !tx_soh) ? SSO_ONES : tx_in_data;
	wire        tx_seed   = tx_row0 && (tx_col == 9'(SSO_SOH_COLS));
	wire [14:0] tx_step   = scr_step(tx_seed ? SSO_SCR_SEED : tx_lfsr);
	wire        tx_scr    = !tx_ctrl[SSO_B_SCR_DIS] && !tx_soh0;
	wire [7:0]  tx_line   = tx_plain ^ (tx_scr ? tx_step[7:0] : SSO_ZERO);

	// Bus slave: zero wait states, always OKAY, read data fetched in the address phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h0000_0000;
			dp_write  <= 1'b0;
			dp_idx    <= 8'h00;
		end else begin
			dp_write <= addr_ok && hwrite;
			if (addr_ok) begin
				dp_idx <= addr_idx;
			end
			if (rd_take) begin
				hrdata <= {24'h00_0000, rd_byte};
			end
		end
	end

	// Software registers; writes are masked, so reserved bits are never stored and read back as zero.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_ctrl <= SSO_REG_RESET;
			tx_ctrl <= SSO_REG_RESET;
			tx_diag <= SSO_REG_RESET;
		end else begin
			if (wr_rx) begin
				rx_ctrl <= wbyte & SSO_RX_CTRL_MASK;
			end
			if (wr_tx) begin
				tx_ctrl <= wbyte & SSO_TX_CTRL_MASK;
			end
			if (wr_diag) begin
				tx_diag <= wbyte & SSO_TX_DIAG_MASK;
			end
		end
	end

	// Sticky status, interrupt output and error counter; a set beats a read clear.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_sticky <= 4'h0;
			// The framer leaves reset hunting, so the detector starts out of frame to avoid a false change.
			alarm_prev <= 4'(1 << SSO_B_OOF_ST);
			sec_irq    <= 1'b0;
			err_count  <= 16'h0000;
			err_snap   <= 16'h0000;
		end else begin
			alarm_prev <= alarm_now;
			irq_sticky <= next_sticky;
			sec_irq    <= |(next_sticky & irq_en);
			err_count  <= next_count;
			if (poll) begin
				err_snap <= err_count;
			end
		end
	end

	// Framer position, state and force request.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			frm_state  <= SSO_HUNT;
			rx_col     <= 9'd0;
			rx_row     <= 4'd0;
			rx_shift   <= 48'h0000_0000_0000;
			bad_frames <= 8'h00;
			force_pend <= 1'b0;
		end else begin
			if (wr_rx && wbyte[SSO_B_FORCE_OOF]) begin
				force_pend <= 1'b1;
			end else if (rx_fp) begin
				force_pend <= 1'b0;
			end
			if (rx_byte_en) begin
				rx_shift <= shift_nx;
				if (frm_state == SSO_HUNT && frm_match) begin
					rx_col <= 9'(SSO_A2_LAST + 1);
					rx_row <= 4'd0;
				end else begin
					rx_col <= rx_col_end ? 9'd0 : rx_col + 9'd1;
					if (rx_col_end) begin
						rx_row <= rx_row_end ? 4'd0 : rx_row + 4'd1;
					end
				end
			end
			unique case (frm_state)
				SSO_HUNT: begin
					if (rx_byte_en && frm_match && !force_pend) begin
						frm_state <= SSO_PRESYNC;
					end
				end
				SSO_PRESYNC: begin
					if (rx_fp) begin
						frm_state <= (frm_match && !force_pend) ? SSO_SYNC : SSO_HUNT;
					end
					bad_frames <= 8'h00;
				end
				SSO_SYNC: begin
					if (rx_fp) begin
						if (force_pend) begin
							frm_state <= SSO_HUNT;
						end else if (frm_match) begin
							bad_frames <= 8'h00;
						end else if (bad_frames == 8'(OOF_BAD_FRAMES - 1)) begin
							frm_state <= SSO_HUNT;
						end else begin
							bad_frames <= bad_frames + 8'h01;
						end
					end
				end
			endcase
		end
	end

	// Loss of frame follows a persistent out-of-frame state; loss of signal follows zero bytes.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lof_frames <= 8'h00;
			lof_state  <= 1'b0;
			zero_bytes <= 16'h0000;
			los_state  <= 1'b0;
		end else begin
			if (rx_fp) begin
				if (oof_state == lof_state) begin
					lof_frames <= 8'h00;
				end else if (lof_frames == 8'(LOF_FRAMES - 1)) begin
					lof_frames <= 8'h00;
					lof_state  <= oof_state;
				end else begin
					lof_frames <= lof_frames + 8'h01;
				end
			end
			if (rx_byte_en) begin
				if (rx_data != SSO_ZERO) begin
					zero_bytes <= 16'h0000;
					los_state  <= 1'b0;
				end else if (zero_bytes == 16'(LOS_ZERO_BYTES - 1)) begin
					los_state  <= 1'b1;
				end else begin
					zero_bytes <= zero_bytes + 16'h0001;
				end
			end
		end
	end

	// Receive descrambler, parity accumulation and output stream.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_lfsr            <= SSO_SCR_SEED;
			rx_bip             <= SSO_ZERO;
			rx_bip_prev        <= SSO_ZERO;
			par_err            <= 1'b0;
			rx_out_valid       <= 1'b0;
			rx_out_data        <= SSO_ZERO;
			rx_out_frame_start <= 1'b0;
		end else begin
			par_err            <= |b1_bits;
			rx_out_valid       <= rx_byte_en;
			rx_out_frame_start <= rx_byte_en && rx_first && !oof_state;
			if (rx_byte_en) begin
				rx_lfsr     <= rx_step[14:8];
				rx_out_data <= rx_clear;
				rx_bip      <= rx_first ? rx_data : rx_bip ^ rx_data;
				if (rx_first) begin
					rx_bip_prev <= rx_bip;
				end
			end
		end
	end

	// Transmit framing, overhead insertion, scrambling and diagnostics.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_col       <= 9'd0;
			tx_row       <= 4'd0;
			ais_on       <= 1'b0;
			tx_lfsr      <= SSO_SCR_SEED;
			tx_bip       <= SSO_ZERO;
			tx_bip_prev  <= SSO_ZERO;
			tx_out_valid <= 1'b0;
			tx_out_data  <= SSO_ZERO;
		end else begin
			tx_out_valid <= tx_byte_en;
			if (tx_byte_en) begin
				tx_col      <= tx_col_end ? 9'd0 : tx_col + 9'd1;
				if (tx_col_end) begin
					tx_row <= tx_row_end ? 4'd0 : tx_row + 4'd1;
				end
				ais_on      <= ais_nx;
				tx_lfsr     <= tx_step[14:8];
				tx_bip      <= tx_first ? tx_line : tx_bip ^ tx_line;
				if (tx_first) begin
					tx_bip_prev <= tx_bip;
				end
				tx_out_data <= tx_diag[SSO_B_ZERO_DIAG] ? SSO_ZERO : tx_line;
			end
		end
	end
endmodule
`default_nettype wire

/* File: sso_line_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sso_line_model
	import sso_pkg::*;
(
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic [1:0] mode,
	input  wire logic [7:0] b1_err,
	output logic            rx_byte_en,
	output logic [7:0]      rx_data
);
	localparam int FRAME = SSO_COLS * SSO_ROWS;
	int         pos;
	logic [7:0] bip;
	logic [7:0] bip_prev;
	logic [7:0] next_byte;
	// Byte chosen for the current slot; mode 1 breaks the first A1, mode 3 the second, mode 2 sends silence.
	always_comb begin
		next_byte = 8'h5A;
		if (pos < SSO_A1_BYTES) begin
			next_byte = SSO_A1;
		end else if (pos <= SSO_A2_LAST) begin
			next_byte = SSO_A2;
		end else if (pos == SSO_COLS * SSO_B1_ROW) begin
			next_byte = bip_prev ^ b1_err;
		end
		if ((mode == 2'd1 && pos == 0) || (mode == 2'd3 && pos == 1) || mode == 2'd2) begin
			next_byte = SSO_ZERO;
		end
	end
	// One byte every cycle; parity covers the whole sent frame so the receiver sees it raw.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_byte_en <= 1'b0;
			rx_data    <= SSO_ZERO;
			pos        <= 0;
			bip        <= SSO_ZERO;
			bip_prev   <= SSO_ZERO;
		end else begin
			rx_byte_en <= 1'b1;
			rx_data    <= next_byte;
			pos        <= (pos == FRAME - 1) ? 0 : pos + 1;
			bip        <= (pos == FRAME - 1) ? SSO_ZERO : bip ^ next_byte;
			if (pos == FRAME - 1) begin
				bip_prev <= bip ^ next_byte;
			end
		end
	end
endmodule
`default_nettype wire

/* File: sso_section_proc_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module sso_section_proc_chk
	import sso_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [7:0]  haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        sec_irq,
	input wire logic        rx_byte_en,
	input wire logic [7:0]  rx_data,
	input wire logic        rx_out_valid,
	input wire logic [7:0]  rx_out_data,
	input wire logic        rx_out_frame_start,
	input wire logic        tx_byte_en,
	input wire logic        tx_out_valid,
	input wire logic [7:0]  tx_out_data
);
	logic       wr_q;
	logic       rd_q;
	logic [5:0] idx_q;
	logic [7:0] rx_ctl;
	logic [2:0] diag;
	logic       mapped;
	assign mapped = idx_q inside {6'h05, [6'h10:6'h15]};
	// The address phase is remembered so that the data phase can be judged.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q  <= 1'b0;
			rd_q  <= 1'b0;
			idx_q <= 6'h00;
		end else if (hready) begin
			wr_q  <= hsel & htrans[1] & hwrite;
			rd_q  <= hsel & htrans[1] & ~hwrite;
			idx_q <= haddr[7:2];
		end
	end
	// Control mirrors; the force bit is write only, so it never reads back.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_ctl <= SSO_REG_RESET;
			diag   <= 3'h0;
		end else if (wr_q && hready) begin
			if (idx_q == 6'h10) begin
				rx_ctl <= hwdata[7:0] & SSO_RX_CTRL_MASK;
			end
			if (idx_q == 6'h15) begin
				diag <= hwdata[2:0];
			end
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_ie_off;
		(rx_ctl[3:0] == 4'h0) [*3];
	endsequence
	// Ten bytes from an in-frame start, the descrambler has just been seeded.
	sequence s_frame_col9;
		rx_out_frame_start && !rx_ctl[6] ##1 rx_out_valid [*8] ##1 rx_out_valid;
	endsequence
	property p_descr_seed; s_frame_col9 |-> rx_out_data == ($past(rx_data) ^ 8'hFE); endproperty
	a_descr_seed: assert property (p_descr_seed) else $error("descrambler seed byte wrong");
	property p_okay; hreadyout && !hresp; endproperty
	a_okay: assert property (p_okay) else $error("bus not ready or not okay");
	property p_rx_valid; rx_out_valid == $past(rx_byte_en); endproperty
	a_rx_valid: assert property (p_rx_valid) else $error("receive valid off its strobe");
	property p_tx_valid; tx_out_valid == $past(tx_byte_en); endproperty
	a_tx_valid: assert property (p_tx_valid) else $error("transmit valid off its strobe");
	property p_unmapped; rd_q && !mapped |-> hrdata == 32'h0000_0000; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_ctl_read; rd_q && idx_q == 6'h10 |-> hrdata == {24'h00_0000, rx_ctl}; endproperty
	a_ctl_read: assert property (p_ctl_read) else $error("receive control readback wrong");
	property p_diag_read; rd_q && idx_q == 6'h15 |-> hrdata == {29'h0000_0000, diag}; endproperty
	a_diag_read: assert property (p_diag_read) else $error("diagnostic readback wrong");
	property p_zero_tx; tx_out_valid && $past(diag[2]) |-> tx_out_data == SSO_ZERO; endproperty
	a_zero_tx: assert property (p_zero_tx) else $error("all zero stream not zero");
	property p_dds_pass; rx_out_valid && $past(rx_ctl[6]) |-> rx_out_data == $past(rx_data); endproperty
	a_dds_pass: assert property (p_dds_pass) else $error("byte altered with descrambler off");
	property p_irq_off; s_ie_off |-> !sec_irq; endproperty
	a_irq_off: assert property (p_irq_off) else $error("interrupt with all enables off");
	property p_fs_valid; rx_out_frame_start |-> rx_out_valid; endproperty
	a_fs_valid: assert property (p_fs_valid) else $error("frame start without byte");
endmodule
bind sso_section_proc sso_section_proc_chk sso_section_proc_chk_i (.*);
`default_nettype wire

/* File: sso_section_proc_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module sso_section_proc_tb import sso_pkg::*;;
	localparam int FRAME = SSO_COLS * SSO_ROWS;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, sec_irq;
	logic        rx_byte_en, rx_out_valid, rx_out_frame_start, tx_byte_en, tx_out_valid;
	logic [1:0]  htrans, line_mode;
	logic [2:0]  hsize;
	logic [7:0]  haddr, rx_data, rx_out_data, tx_in_data, tx_out_data, b1_err;
	logic [31:0] hwdata, hrdata;
	int          miscompares = 0;
	int          comparisons = 0;
	int          cycles = 0;
	sso_section_proc #(.OOF_BAD_FRAMES(4), .LOF_FRAMES(2), .LOS_ZERO_BYTES(8)) sso_section_proc_i (
		.hready(hreadyout), .*);
	sso_line_model sso_line_model_i (.mode(line_mode), .*);
	// Clock at 200 MHz.
	always #2.5 hclk = ~hclk;
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run();
		if (miscompares == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// One single word transfer; the address phase holds until the slave is ready.
	task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr  <= {idx[5:0], 2'b00};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		logic [31:0] unused;
		ahb(1'b1, idx, {24'h00_0000, wd}, unused);
	endtask
	// Upper bits are always checked to be zero; the mask selects the byte fields of interest.
	task automatic rdc(input string what, input logic [7:0] idx, input logic [7:0] mask, input logic [7:0] exp);
		logic [31:0] got;
		ahb(1'b0, idx, 32'h0000_0000, got);
		chk(what, {24'h00_0000, exp}, got & {24'hFF_FFFF, mask});
	endtask
	task automatic irq(input logic exp);
		chk("sec_irq", {31'h0000_0000, exp}, {31'h0000_0000, sec_irq});
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// The strobe is lowered only when no byte follows at once, so it is never assigned twice in a step.
	task automatic tx_fill(input int n, input logic stop);
		tx_in_data <= SSO_ZERO;
		tx_byte_en <= 1'b1;
		repeat (n) @(posedge hclk);
		if (stop) begin
			tx_byte_en <= 1'b0;
		end
	endtask
	// Output is looked at mid-cycle, then the driver realigns to the rising edge.
	task automatic tx_one(input logic [7:0] din, input logic [7:0] exp);
		tx_in_data <= din;
		tx_byte_en <= 1'b1;
		@(posedge hclk);
		tx_byte_en <= 1'b0;
		@(negedge hclk);
		chk("tx_out_data", {24'h00_0000, exp}, {24'h00_0000, tx_out_data});
		@(posedge hclk);
	endtask
	// A hung handshake would otherwise stall the run forever.
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 90000) begin
			miscompares++;
			complete_run();
		end
	end
	// Main sequence: registers, transmit insertion, then the receive alarms and counters.
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		haddr = 8'h00;
		hwdata = 32'h0000_0000;
		tx_byte_en = 1'b0;
		tx_in_data = 8'h00;
		line_mode = 2'd0;
		b1_err = 8'h00;
		idle(20);
		hresetn <= 1'b1;
		idle(1);
		rdc("rx_ctl", SSO_IDX_RX_CTRL, 8'hFF, 8'h00);
		rdc("tx_ctl", SSO_IDX_TX_CTRL, 8'hFF, 8'h00);
		rdc("unmapped", 8'h20, 8'hFF, 8'h00);
		wr(SSO_IDX_RX_CTRL, 8'hFF);
		rdc("rx_ctl", SSO_IDX_RX_CTRL, 8'hFF, 8'hDF);
		wr(SSO_IDX_RX_CTRL, 8'h40);
		wr(SSO_IDX_TX_DIAG, 8'hFF);
		rdc("diag", SSO_IDX_TX_DIAG, 8'hFF, 8'h07);
		wr(SSO_IDX_TX_DIAG, 8'h01);
		for (int i = 0; i < 6; i++) tx_one(8'h11, (i < 3) ? SSO_A1_BAD : SSO_A2);
		wr(SSO_IDX_TX_DIAG, 8'h00);
		tx_fill(FRAME - 6, 1'b0);
		tx_one(8'h11, SSO_A1);
		wr(SSO_IDX_TX_DIAG, 8'h04);
		tx_one(8'h11, SSO_ZERO);
		wr(SSO_IDX_TX_DIAG, 8'h00);
		tx_fill(18, 1'b1);
		wr(SSO_IDX_TX_CTRL, 8'h41);
		tx_one(8'h12, 8'h12);
		tx_fill(FRAME - 12, 1'b0);
		tx_one(8'h12, SSO_ONES);
		wr(SSO_IDX_TX_CTRL, 8'h00);
		tx_fill(FRAME - 1, 1'b0);
		tx_one(8'h00, 8'hFE);
		idle(3 * FRAME);
		rdc("state", SSO_IDX_RX_STAT, 8'h07, 8'h00);
		b1_err <= 8'h03;
		idle(FRAME);
		wr(SSO_IDX_CNT_LOW, 8'h00);
		idle(2 * FRAME - 2);
		wr(SSO_IDX_CNT_HIGH, 8'h00);
		idle(8);
		rdc("count_low", SSO_IDX_CNT_LOW, 8'hFF, 8'h04);
		rdc("count_high", SSO_IDX_CNT_HIGH, 8'hFF, 8'h00);
		wr(SSO_IDX_RX_CTRL, 8'hC8);
		wr(SSO_IDX_PERF_LOAD, 8'h00);
		idle(2 * FRAME - 2);
		wr(SSO_IDX_PERF_LOAD, 8'h00);
		idle(8);
		rdc("count_low", SSO_IDX_CNT_LOW, 8'hFF, 8'h02);
		irq(1'b1);
		b1_err <= 8'h00;
		idle(FRAME);
		rdc("status", SSO_IDX_RX_STAT, 8'h40, 8'h40);
		rdc("status", SSO_IDX_RX_STAT, 8'h40, 8'h00);
		idle(2);
		irq(1'b0);
		wr(SSO_IDX_RX_CTRL, 8'h50);
		line_mode <= 2'd3;
		idle(5 * FRAME);
		rdc("state", SSO_IDX_RX_STAT, 8'h01, 8'h00);
		wr(SSO_IDX_RX_CTRL, 8'h43);
		idle(7 * FRAME);
		irq(1'b1);
		rdc("status", SSO_IDX_RX_STAT, 8'h1B, 8'h1B);
		rdc("status", SSO_IDX_RX_STAT, 8'h18, 8'h00);
		idle(2);
		irq(1'b0);
		wr(SSO_IDX_RX_CTRL, 8'h44);
		line_mode <= 2'd2;
		idle(20);
		irq(1'b1);
		rdc("status", SSO_IDX_RX_STAT, 8'h24, 8'h24);
		line_mode <= 2'd0;
		idle(20);
		rdc("state", SSO_IDX_RX_STAT, 8'h04, 8'h00);
		wr(SSO_IDX_RX_CTRL, 8'h00);
		idle(5 * FRAME);
		rdc("state", SSO_IDX_RX_STAT, 8'h03, 8'h00);
		wr(SSO_IDX_RX_CTRL, 8'h60);
		idle(FRAME + 50);
		rdc("state", SSO_IDX_RX_STAT, 8'h01, 8'h01);
		rdc("rx_ctl", SSO_IDX_RX_CTRL, 8'hFF, 8'h40);
		complete_run();
	end
endmodule
`default_nettype wire
